// ### rtl/gpio_pkg.sv
package gpio_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  // register offsets (byte addresses are four times these)
  localparam logic [7:0]  OFF_PORT_DATA   = 8'h06;
  localparam logic [7:0]  OFF_CONFIG      = 8'h81;
  localparam logic [7:0]  OFF_DIRECTION   = 8'h86;
  localparam logic [7:0]  OFF_INT_CTRL    = 8'h8b;
  localparam logic [7:0]  OFF_ALT_ENABLE  = 8'h90;
  localparam logic [7:0]  OFF_ALT_OUT     = 8'h91;
  localparam logic [7:0]  OFF_SLEEP       = 8'h92;
  // field positions
  localparam int          PULLUP_DIS_BIT  = 7;
  localparam int          CHANGE_FLAG_BIT = 0;
  localparam int          CHANGE_LO       = 4;
  localparam int          CHANGE_HI       = 7;
  // reset values
  localparam logic [7:0]  CONFIG_RST      = 8'hff;
  localparam logic [7:0]  DIRECTION_RST   = 8'hff;
  localparam logic [7:0]  INT_CTRL_RST    = 8'h00;
  localparam logic [7:0]  LATCH_RST       = 8'h00;
  localparam logic [7:0]  ZERO8           = 8'h00;
  // bus answer: waitrequest held for one cycle, answer on the second
  localparam int          BUS_WAIT_CYCLES = 1;
endpackage

// ### rtl/port_access_if.sv
`timescale 1ns/1ps
interface port_access_if;
  logic       read_pulse;
  logic       write_pulse;
  logic [7:0] pins;
  logic [7:0] direction;
  logic       mismatch;
  modport core (output read_pulse, output write_pulse, output pins, output direction,
                input mismatch);
  modport det  (input read_pulse, input write_pulse, input pins, input direction,
                output mismatch);
endinterface // port_access_if

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] pin_async,
  output logic      [7:0] pin_sync_out
);
  logic [7:0] stage1;

  // two flops; only the second stage is read by anyone
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1       <= gpio_pkg::ZERO8;
      pin_sync_out <= gpio_pkg::ZERO8;
    end else begin
      stage1       <= pin_async;
      pin_sync_out <= stage1;
    end
  end
endmodule // pin_sync

// ### rtl/change_detect.sv
`timescale 1ns/1ps
module change_detect (
  input  wire logic   clk,
  input  wire logic   rst,
  port_access_if.det  acc
);
  logic [7:0] snapshot;
  logic [3:0] bit_mismatch;

  // snapshot refreshed on every port read or write, ending the mismatch
  always_ff @(posedge clk) begin
    if (rst) begin
      snapshot <= gpio_pkg::ZERO8;
    end else if (acc.read_pulse || acc.write_pulse) begin
      snapshot <= acc.pins;
    end
  end

  genvar g;
  generate
    for (g = gpio_pkg::CHANGE_LO; g <= gpio_pkg::CHANGE_HI; g++) begin : g_cmp
      // outputs never compare
      assign bit_mismatch[g - gpio_pkg::CHANGE_LO] =
        acc.direction[g] && (acc.pins[g] != snapshot[g]);
    end
  endgenerate

  // a change landing in the access cycle still sets the flag: mismatch uses the old snapshot
  assign acc.mismatch = |bit_mismatch;
endmodule // change_detect

// ### rtl/gpio_port_change_interrupt.sv
`timescale 1ns/1ps
// Operation
// - eight-bit bidirectional port, each pin with its own direction bit.
// - direction one leaves pin undriven; zero drives it from the output latch.
// - an enabled alternate function owns the pin whatever its direction bit.
// - port read returns pin levels; port write updates the output latch.
// - port writes store the written byte to the latch whole; pins go only to the snapshot.
// - one pullup disable bit; one disables all, zero follows latch bits.
// - pullup forced off on any pin configured as output.
// - pullup disable bit reads one after reset.
// - only upper four pins, and only inputs, take part in change detection.
// - inputs compared with value sampled at last port read or write; ORed mismatch sets change flag bit 0.
// - pending change flag can wake the device from sleep.
// - mismatch keeps setting the flag; software ends mismatch then clears flag.
// - a change landing in the port read's access cycle still sets the flag.
// - flag sets regardless of its enable or the global enable.
module gpio_port_change_interrupt (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pullup_en,
  input  wire logic [7:0]  alt_out_periph,
  output logic             change_int_flag,
  output logic             wake
);
  port_access_if acc ();

  logic [7:0] port_latch;
  logic [7:0] port_b_direction;
  logic [7:0] prescaler_edge_pullup_config;
  logic [7:0] interrupt_control_flags;
  logic [7:0] alt_enable;
  logic       sleep_mode;
  logic [7:0] pins_synced;
  logic       answered;
  logic       access;
  logic       do_write;
  logic       do_read;
  logic       lane0;
  logic [7:0] reg_idx;
  logic       mapped;
  logic [7:0] wdata;
  logic       pullup_disable;

  function automatic logic is_mapped(input logic [7:0] idx);
    return idx == gpio_pkg::OFF_PORT_DATA || idx == gpio_pkg::OFF_CONFIG ||
           idx == gpio_pkg::OFF_DIRECTION || idx == gpio_pkg::OFF_INT_CTRL ||
           idx == gpio_pkg::OFF_ALT_ENABLE || idx == gpio_pkg::OFF_SLEEP;
  endfunction

  pin_sync u_sync (
    .clk          (clk),
    .rst          (rst),
    .pin_async    (pin_in),
    .pin_sync_out (pins_synced)
  );

  change_detect u_det (
    .clk (clk),
    .rst (rst),
    .acc (acc.det)
  );

  // bus slave: one wait cycle then the answer
  assign access          = (avs_read || avs_write) && !answered;
  assign avs_waitrequest = access;
  assign do_write        = avs_write && answered;
  assign do_read         = avs_read && answered;
  assign reg_idx         = avs_address[9:2];
  assign mapped          = is_mapped(reg_idx);
  assign lane0           = avs_byteenable[0];
  assign wdata           = avs_writedata[7:0];
  assign pullup_disable  = prescaler_edge_pullup_config[gpio_pkg::PULLUP_DIS_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      answered <= 1'b0;
    end else begin
      answered <= access;
    end
  end

  // read data registered at the answer edge
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (access && avs_read) begin
      avs_readdata <= 32'h00000000;
      unique case (1'b1)
        reg_idx == gpio_pkg::OFF_PORT_DATA:  avs_readdata[7:0] <= pins_synced;
        reg_idx == gpio_pkg::OFF_CONFIG:     avs_readdata[7:0] <= prescaler_edge_pullup_config;
        reg_idx == gpio_pkg::OFF_DIRECTION:  avs_readdata[7:0] <= port_b_direction;
        reg_idx == gpio_pkg::OFF_INT_CTRL:   avs_readdata[7:0] <= interrupt_control_flags;
        reg_idx == gpio_pkg::OFF_ALT_ENABLE: avs_readdata[7:0] <= alt_enable;
        reg_idx == gpio_pkg::OFF_SLEEP:      avs_readdata[0]   <= sleep_mode;
        default:                             avs_readdata      <= 32'h00000000;
      endcase
    end
  end

  assign acc.read_pulse  = do_read && reg_idx == gpio_pkg::OFF_PORT_DATA;
  assign acc.write_pulse = do_write && lane0 && reg_idx == gpio_pkg::OFF_PORT_DATA;
  assign acc.pins        = pins_synced;
  assign acc.direction   = port_b_direction;

  // latch write is whole-byte; the pins are sampled into the snapshot at the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      port_latch <= gpio_pkg::LATCH_RST;
    end else if (acc.write_pulse) begin
      port_latch <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_b_direction <= gpio_pkg::DIRECTION_RST;
    end else if (do_write && lane0 && reg_idx == gpio_pkg::OFF_DIRECTION) begin
      port_b_direction <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prescaler_edge_pullup_config <= gpio_pkg::CONFIG_RST;
    end else if (do_write && lane0 && reg_idx == gpio_pkg::OFF_CONFIG) begin
      prescaler_edge_pullup_config <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alt_enable <= gpio_pkg::ZERO8;
    end else if (do_write && lane0 && reg_idx == gpio_pkg::OFF_ALT_ENABLE) begin
      alt_enable <= wdata;
    end
  end

  // change flag: set beats software clear, enables have no say
  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_control_flags <= gpio_pkg::INT_CTRL_RST;
    end else begin
      if (do_write && lane0 && reg_idx == gpio_pkg::OFF_INT_CTRL) begin
        interrupt_control_flags <= wdata;
      end
      if (acc.mismatch) begin
        interrupt_control_flags[gpio_pkg::CHANGE_FLAG_BIT] <= 1'b1;
      end
    end
  end

  assign change_int_flag = interrupt_control_flags[gpio_pkg::CHANGE_FLAG_BIT];

  // sleep ends as soon as a change is pending
  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_mode <= 1'b0;
    end else if (change_int_flag) begin
      sleep_mode <= 1'b0;
    end else if (do_write && lane0 && reg_idx == gpio_pkg::OFF_SLEEP) begin
      sleep_mode <= wdata[0];
    end
  end

  assign wake = sleep_mode && change_int_flag;

  // pin drivers and pullups
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out   <= gpio_pkg::ZERO8;
      pin_oe    <= gpio_pkg::ZERO8;
      pullup_en <= gpio_pkg::ZERO8;
    end else begin
      for (int i = 0; i < gpio_pkg::DATA_W; i++) begin
        pin_out[i]   <= alt_enable[i] ? alt_out_periph[i] : port_latch[i];
        pin_oe[i]    <= alt_enable[i] | ~port_b_direction[i];
        pullup_en[i] <= ~pullup_disable & port_b_direction[i] & port_latch[i];
      end
    end
  end

  logic unused_ok;
  assign unused_ok = mapped;

  chk_flag_sets_after_mismatch: assert property (@(posedge clk) disable iff (rst)
    acc.mismatch |=> change_int_flag) else $error("mismatch did not set flag");

  chk_outputs_no_compare: assert property (@(posedge clk) disable iff (rst)
    (port_b_direction[7:4] == 4'h0) |-> !acc.mismatch) else $error("output compared");

  chk_pullup_off_output: assert property (@(posedge clk) disable iff (rst)
    $past(!port_b_direction[0]) |-> !pullup_en[0]) else $error("pullup on output");

  chk_pullup_disable_all: assert property (@(posedge clk) disable iff (rst)
    $past(pullup_disable) |-> pullup_en == 8'h00) else $error("pullup not disabled");

  chk_drive_from_latch: assert property (@(posedge clk) disable iff (rst)
    $past(!port_b_direction[1] && !alt_enable[1]) |-> pin_oe[1] && pin_out[1] == $past(port_latch[1]))
    else $error("pin not driven from latch");

  chk_alt_takes_pin: assert property (@(posedge clk) disable iff (rst)
    $past(alt_enable[2]) |-> pin_oe[2]) else $error("alternate function lost pin");

  chk_flag_held_mismatch: assert property (@(posedge clk) disable iff (rst)
    change_int_flag && acc.mismatch |=> change_int_flag) else $error("flag cleared early");

  chk_wake_clears_sleep: assert property (@(posedge clk) disable iff (rst)
    sleep_mode && change_int_flag |=> !sleep_mode) else $error("no wake from sleep");
endmodule // gpio_port_change_interrupt

// ### test/keypad_model.sv
`timescale 1ns/1ps
module keypad_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] keys,
  output logic      [7:0] pin_level
);
  // a floating pin shows a moving pattern so a stale level never passes
  logic [7:0] float_pat;
  initial float_pat = 8'h55;
  always @(posedge clk) begin
    float_pat <= ~float_pat;
  end
  // a pressed key shorts its pin low unless the device drives it
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] :
                     (keys[i] ? 1'b0 : (pullup_en[i] ? 1'b1 : float_pat[i]));
    end
  end
endmodule // keypad_model

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  pin_in, pin_out, pin_oe, pullup_en;
  logic [7:0]  alt_out_periph = 8'h00;
  logic [7:0]  keys = 8'h00;
  logic        change_int_flag, wake;
  logic [7:0]  rd;
  int          failures = 0;
  int          n_tests = 0;

  always #25 clk = ~clk;

  gpio_port_change_interrupt i_gpio_port_change_interrupt (.clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .pullup_en, .alt_out_periph,
    .change_int_flag, .wake);
  keypad_model i_keypad_model (.clk, .pin_out, .pin_oe, .pullup_en, .keys,
    .pin_level(pin_in));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask

  task automatic rdr(input logic [7:0] idx);
    bus(1'b0, idx, 8'h00, 4'hf);
  endtask

  // bounded wait on the flag or on the wake output
  task automatic wait_hi(input logic sel);
    int n;
    n = 0;
    while ((sel ? wake : change_int_flag) !== 1'b1 && n < 12) begin
      @(posedge clk);
      n++;
    end
    check8({7'h0, sel ? wake : change_int_flag}, 8'h01);
  endtask

  task automatic t_reset();
    check8(pin_oe, 8'h00);
    check8(pullup_en, 8'h00);
    rdr(gpio_pkg::OFF_CONFIG);
    check8(rd, 8'hff);
    bus(1'b1, gpio_pkg::OFF_DIRECTION, 8'h00, 4'h0);
    rdr(gpio_pkg::OFF_DIRECTION);
    check8(rd, 8'hff);
    rdr(gpio_pkg::OFF_INT_CTRL);
    check8(rd & 8'hfe, 8'h00);
    rdr(8'h50);
    check8(rd, 8'h00);
  endtask

  task automatic t_drive();
    wr(gpio_pkg::OFF_PORT_DATA, 8'ha5);
    wr(gpio_pkg::OFF_DIRECTION, 8'hf0);
    repeat (2) @(posedge clk);
    check8(pin_oe, 8'h0f);
    check8(pin_out & 8'h0f, 8'h05);
    check8(pullup_en, 8'h00);
    wr(gpio_pkg::OFF_CONFIG, 8'h7f);
    repeat (4) @(posedge clk);
    check8(pullup_en, 8'ha0);
    rdr(gpio_pkg::OFF_PORT_DATA);
    check8(rd & 8'haf, 8'ha5);
    wr(gpio_pkg::OFF_DIRECTION, 8'hff);
  endtask

  task automatic t_change();
    wr(gpio_pkg::OFF_PORT_DATA, 8'hff);
    repeat (4) @(posedge clk);
    rdr(gpio_pkg::OFF_PORT_DATA);
    check8(rd, 8'hff);
    wr(gpio_pkg::OFF_INT_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    check8({7'h0, change_int_flag}, 8'h00);
    keys <= 8'h01;
    repeat (8) @(posedge clk);
    check8({7'h0, change_int_flag}, 8'h00);
    keys <= 8'h21;
    // no port reads while waiting; a read would refresh the snapshot but still set the flag
    wait_hi(1'b0);
    wr(gpio_pkg::OFF_INT_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    check8({7'h0, change_int_flag}, 8'h01);
    rdr(gpio_pkg::OFF_PORT_DATA);
    check8(rd, 8'hde);
    wr(gpio_pkg::OFF_INT_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    check8({7'h0, change_int_flag}, 8'h00);
    // an upper pin turned output and toggled must not raise the flag
    wr(gpio_pkg::OFF_DIRECTION, 8'h7f);
    wr(gpio_pkg::OFF_PORT_DATA, 8'h7f);
    repeat (8) @(posedge clk);
    check8({7'h0, change_int_flag}, 8'h00);
    wr(gpio_pkg::OFF_PORT_DATA, 8'hff);
    wr(gpio_pkg::OFF_DIRECTION, 8'hff);
    repeat (4) @(posedge clk);
    rdr(gpio_pkg::OFF_PORT_DATA);
    wr(gpio_pkg::OFF_INT_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    check8({7'h0, change_int_flag}, 8'h00);
  endtask

  task automatic t_wake();
    wr(gpio_pkg::OFF_SLEEP, 8'h01);
    keys <= 8'h00;
    wait_hi(1'b1);
    check8({7'h0, change_int_flag}, 8'h01);
    rdr(gpio_pkg::OFF_PORT_DATA);
    wr(gpio_pkg::OFF_INT_CTRL, 8'h00);
  endtask

  task automatic t_alt();
    alt_out_periph <= 8'h02;
    wr(gpio_pkg::OFF_ALT_ENABLE, 8'h02);
    repeat (2) @(posedge clk);
    check8(pin_oe, 8'h02);
    check8(pin_out & 8'h02, 8'h02);
    alt_out_periph <= 8'h00;
    repeat (2) @(posedge clk);
    check8(pin_out & 8'h02, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_drive();
    t_change();
    t_wake();
    t_alt();
    tally_and_finish();
  end
endmodule // tb_top
